// *** rtl/fcr_pkg.sv ***
// Purpose: constants for the clock ratio frequency counter
// Assumes: 8-bit special register port, byte-wide extended register port
// Notes: shared by the counter top and the tally module
//
// What this block does
// RULE1: mode zero disables and stops counting at once
// RULE2: nonzero mode enables, waits idle for trigger
// RULE3: writing busy one triggers and clears done
// RULE4: software may clear done after reading tally
// RULE5: after sync delay, first interval edge starts
// RULE6: interval edge after programmed length stops counting
// RULE7: busy falls, done set few cycles later
// RULE8: counters halt, tally holds until disable/retrigger
// RULE9: tally 23 bits, read as four bytes
// RULE10: reading while busy returns live value
// RULE11: retrigger while busy clears tally and restarts
// RULE12: length is (2+bit0) times 2 pow bits5:1
// RULE13: exponent above 43 gives one cycle
// RULE14: software avoids tally overflow unless wanted
// RULE15: done is a level interrupt until cleared
// RULE16: done accepts any write, one raises interrupt
// RULE17: select bit picks lc or divider clock
// RULE18: both counted clocks inactive while disabled
// RULE19: mode selects interval source, two codes reserved
// RULE20: control bits 4:3 read zero, ignore writes
// RULE21: exponent six bits low, upper two reserved
// RULE22: longword upper bits zero, big endian bytes
// RULE23: tally wraps modulo 2 pow 23 silently
package fcr_pkg;
    localparam int TALLY_W = 23;
    localparam int EXP_W = 6;
    localparam int MODE_W = 3;
    // special register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h9B;
    localparam logic [7:0] ADDR_EXP = 8'h9D;
    // extended register byte addresses of the longword
    localparam logic [15:0] ADDR_TALLY0 = 16'h4008;
    localparam logic [15:0] ADDR_TALLY1 = 16'h4009;
    localparam logic [15:0] ADDR_TALLY2 = 16'h400A;
    localparam logic [15:0] ADDR_TALLY3 = 16'h400B;
    // control fields
    localparam int BIT_DONE = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_SEL = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [EXP_W-1:0] EXP_RESET = 6'h00;
    localparam logic [EXP_W-1:0] EXP_MAX = 6'h2B;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    // mode codes
    localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
    localparam logic [MODE_W-1:0] MODE_GPIO = 3'h1;
    localparam logic [MODE_W-1:0] MODE_OSC24 = 3'h2;
    localparam logic [MODE_W-1:0] MODE_SYSCLK = 3'h3;
    localparam logic [MODE_W-1:0] MODE_XO = 3'h4;
    localparam logic [MODE_W-1:0] MODE_SLEEP = 3'h6;
    // synchronisation delays in system clock cycles
    localparam logic [1:0] START_SYNC_CYCLES = 2'h2;
    localparam int DONE_SYNC_CYCLES = 2;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SYNC,
        ST_WAIT_EDGE,
        ST_COUNTING
    } fcr_state_t;
endpackage

// *** rtl/fcr_tally_if.sv ***
// Purpose: carries tally control and value between the two modules
// Assumes: one clock domain
// Notes: ctrl side steers, cnt side holds the counter
`timescale 1ns/1ps
interface fcr_tally_if;
    logic clk_en;
    logic clear;
    logic step;
    logic [fcr_pkg::TALLY_W-1:0] value;
    modport ctrl (output clk_en, output clear, output step, input value);
    modport cnt (input clk_en, input clear, input step, output value);
endinterface

// *** rtl/fcr_tally.sv ***
// Purpose: 23-bit main tally counter
// Assumes: step is one cycle per counted clock rising edge
// Notes: clear wins over step
`timescale 1ns/1ps
module fcr_tally (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // control and value
    fcr_tally_if.cnt tif
);
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tif.value <= '0;
        end else if (tif.clk_en) begin
            if (tif.clear) begin
                tif.value <= '0; // RULE11
            end else if (tif.step) begin
                // wraps with no flag or saturation
                tif.value <= tif.value + 1'b1; // RULE23
            end
        end
    end
endmodule

// *** rtl/fcr_counter.sv ***
// Purpose: clock ratio frequency counter with its control registers
// Assumes: all clock sources arrive as levels sampled on i_clock
// Notes: counted and interval clocks must be no faster than half i_clock
`timescale 1ns/1ps
module fcr_counter (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // special register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // extended register port, read only here
    input wire logic [15:0] i_xreg_addr,
    input wire logic i_xreg_rd,
    output logic [7:0] o_xreg_rdata,
    // interval clock sources
    input wire logic i_gpio_ref_clk,
    input wire logic i_osc24_clk,
    input wire logic i_crystal_ref_clock,
    input wire logic i_sleep_tick_clk,
    // counted clocks and their enables
    input wire logic i_lc_tank_oscillator,
    input wire logic i_divider_clk,
    output logic o_lc_osc_en,
    output logic o_divider_en,
    // level interrupt request
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////
    // registers and state
    logic [fcr_pkg::MODE_W-1:0] counter_mode_sel;
    logic counted_clock_sel;
    logic count_finished;
    logic [fcr_pkg::EXP_W-1:0] interval_exponent;
    fcr_pkg::fcr_state_t state;
    logic [1:0] sync_cnt;
    logic [fcr_pkg::TALLY_W-1:0] ivl_cnt;
    logic ivl_prev;
    logic cnt_prev;
    logic busy_q;
    logic [fcr_pkg::DONE_SYNC_CYCLES-1:0] done_pipe;
    fcr_tally_if tif ();

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [fcr_pkg::TALLY_W-1:0] interval_len(
        input logic [fcr_pkg::EXP_W-1:0] e);
        logic [fcr_pkg::TALLY_W-1:0] base;
        base = e[0] ? fcr_pkg::TALLY_W'(3) : fcr_pkg::TALLY_W'(2);
        if (e > fcr_pkg::EXP_MAX) begin
            interval_len = fcr_pkg::TALLY_W'(1); // RULE13
        end else begin
            interval_len = base << e[5:1]; // RULE12
        end
    endfunction

    function automatic logic src_level(
        input logic [fcr_pkg::MODE_W-1:0] m,
        input logic gpio, input logic osc, input logic xo,
        input logic slp);
        case (m) // RULE19
            fcr_pkg::MODE_GPIO: src_level = gpio;
            fcr_pkg::MODE_OSC24: src_level = osc;
            fcr_pkg::MODE_XO: src_level = xo;
            fcr_pkg::MODE_SLEEP: src_level = slp;
            default: src_level = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // decode
    logic ctrl_wr;
    logic exp_wr;
    logic enabled;
    logic trigger;
    logic ivl_level;
    logic ivl_tick;
    logic cnt_level;
    logic cnt_edge;
    logic last_tick;
    logic busy;
    logic busy_fall;

    assign ctrl_wr = i_sfr_wr && (i_sfr_addr == fcr_pkg::ADDR_CTRL);
    assign exp_wr = i_sfr_wr && (i_sfr_addr == fcr_pkg::ADDR_EXP);
    assign enabled = (counter_mode_sel != fcr_pkg::MODE_OFF);
    // trigger only counts when the written mode is nonzero
    assign trigger = ctrl_wr && i_sfr_wdata[fcr_pkg::BIT_BUSY] &&
        (i_sfr_wdata[fcr_pkg::MODE_W-1:0] != fcr_pkg::MODE_OFF); // RULE3
    assign ivl_level = src_level(counter_mode_sel, i_gpio_ref_clk,
        i_osc24_clk, i_crystal_ref_clock, i_sleep_tick_clk);
    // system clock as interval source ticks every cycle
    assign ivl_tick = (counter_mode_sel == fcr_pkg::MODE_SYSCLK) ||
        (ivl_level && !ivl_prev);
    assign cnt_level = counted_clock_sel ? i_divider_clk
                                         : i_lc_tank_oscillator; // RULE17
    assign cnt_edge = cnt_level && !cnt_prev;
    assign last_tick = (ivl_cnt + 1'b1) == interval_len(interval_exponent);
    assign busy = (state != fcr_pkg::ST_IDLE);
    assign busy_fall = busy_q && !busy;

    ////////////////////////////////////////////////////////////////////
    // control register fields
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            counter_mode_sel <= fcr_pkg::MODE_OFF;
            counted_clock_sel <= 1'b0;
        end else if (i_clk_en && ctrl_wr) begin
            // bits 4:3 are not stored
            counter_mode_sel <= i_sfr_wdata[fcr_pkg::MODE_W-1:0]; // RULE20
            counted_clock_sel <= i_sfr_wdata[fcr_pkg::BIT_SEL];
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            interval_exponent <= fcr_pkg::EXP_RESET;
        end else if (i_clk_en && exp_wr) begin
            interval_exponent <= i_sfr_wdata[fcr_pkg::EXP_W-1:0]; // RULE21
        end
    end

    ////////////////////////////////////////////////////////////////////
    // measurement sequencer
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= fcr_pkg::ST_IDLE;
            sync_cnt <= '0;
            ivl_cnt <= '0;
        end else if (i_clk_en) begin
            if (ctrl_wr &&
                i_sfr_wdata[fcr_pkg::MODE_W-1:0] == fcr_pkg::MODE_OFF) begin
                state <= fcr_pkg::ST_IDLE; // RULE1
            end else if (trigger) begin
                state <= fcr_pkg::ST_SYNC; // RULE11
                sync_cnt <= '0;
            end else if (!enabled) begin
                state <= fcr_pkg::ST_IDLE; // RULE2
            end else begin
                case (state)
                    fcr_pkg::ST_IDLE: begin
                        state <= fcr_pkg::ST_IDLE; // RULE2
                    end
                    fcr_pkg::ST_SYNC: begin
                        if (sync_cnt ==
                            fcr_pkg::START_SYNC_CYCLES - 2'h1) begin
                            state <= fcr_pkg::ST_WAIT_EDGE; // RULE5
                        end
                        sync_cnt <= sync_cnt + 2'h1;
                    end
                    fcr_pkg::ST_WAIT_EDGE: begin
                        if (ivl_tick) begin
                            state <= fcr_pkg::ST_COUNTING; // RULE5
                            ivl_cnt <= '0;
                        end
                    end
                    fcr_pkg::ST_COUNTING: begin
                        if (ivl_tick && last_tick) begin
                            state <= fcr_pkg::ST_IDLE; // RULE6
                        end else if (ivl_tick) begin
                            ivl_cnt <= ivl_cnt + 1'b1;
                        end
                    end
                    default: begin
                        state <= fcr_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // edge samplers for interval and counted clocks
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ivl_prev <= 1'b0;
            cnt_prev <= 1'b0;
        end else if (i_clk_en) begin
            ivl_prev <= ivl_level;
            cnt_prev <= cnt_level;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // done flag: busy falling edge passes a short delay line
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_q <= 1'b0;
            done_pipe <= '0;
        end else if (i_clk_en) begin
            busy_q <= busy;
            if (!enabled) begin
                // an abort by disable is not a finished measurement
                done_pipe <= '0;
            end else begin
                done_pipe <= {done_pipe[fcr_pkg::DONE_SYNC_CYCLES-2:0],
                              busy_fall}; // RULE7
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_finished <= 1'b0;
        end else if (i_clk_en) begin
            if (done_pipe[fcr_pkg::DONE_SYNC_CYCLES-1]) begin
                // hardware set wins over a same-cycle clear
                count_finished <= 1'b1; // RULE7
            end else if (trigger) begin
                count_finished <= 1'b0; // RULE3
            end else if (ctrl_wr) begin
                count_finished <= i_sfr_wdata[fcr_pkg::BIT_DONE]; // RULE16
            end
        end
    end

    assign o_irq = count_finished; // RULE15

    ////////////////////////////////////////////////////////////////////
    // main tally
    assign tif.clk_en = i_clk_en;
    // disable or retrigger clears; tally otherwise holds after the interval
    assign tif.clear = trigger || !enabled; // RULE8
    // counted edges only between the two interval edges
    assign tif.step = (state == fcr_pkg::ST_COUNTING) && cnt_edge; // RULE6

    fcr_tally u_tally (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .tif(tif)
    );

    // counted clock enables, both idle while disabled
    assign o_lc_osc_en = enabled && !counted_clock_sel; // RULE18
    assign o_divider_en = enabled && counted_clock_sel; // RULE18

    ////////////////////////////////////////////////////////////////////
    // read data, one cycle after the read strobe
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sfr_rdata <= fcr_pkg::UNMAPPED_DATA;
        end else if (i_clk_en && i_sfr_rd) begin
            if (i_sfr_addr == fcr_pkg::ADDR_CTRL) begin
                o_sfr_rdata <= {count_finished, busy, counted_clock_sel,
                                2'b00, counter_mode_sel}; // RULE20
            end else if (i_sfr_addr == fcr_pkg::ADDR_EXP) begin
                o_sfr_rdata <= {2'b00, interval_exponent}; // RULE21
            end else begin
                o_sfr_rdata <= fcr_pkg::UNMAPPED_DATA;
            end
        end
    end

    // live value, no snapshot: bytes may tear while busy
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_xreg_rdata <= fcr_pkg::UNMAPPED_DATA;
        end else if (i_clk_en && i_xreg_rd) begin
            case (i_xreg_addr) // RULE9 RULE10
                fcr_pkg::ADDR_TALLY0: o_xreg_rdata <= 8'h00; // RULE22
                fcr_pkg::ADDR_TALLY1: o_xreg_rdata <= {1'b0, tif.value[22:16]};
                fcr_pkg::ADDR_TALLY2: o_xreg_rdata <= tif.value[15:8];
                fcr_pkg::ADDR_TALLY3: o_xreg_rdata <= tif.value[7:0];
                default: o_xreg_rdata <= fcr_pkg::UNMAPPED_DATA;
            endcase
        end
    end
endmodule

// *** sim/fcr_monitor.sv ***
// Purpose: port-level checks of the frequency counter
// Assumes: sees only the top ports, one clock domain
// Notes: bound into fcr_counter below
`timescale 1ns/1ps
module fcr_monitor (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // register ports
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic [15:0] i_xreg_addr,
    input wire logic i_xreg_rd,
    input wire logic [7:0] o_xreg_rdata,
    // enables and request
    input wire logic o_lc_osc_en,
    input wire logic o_divider_en,
    input wire logic o_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic wr_c;
    logic on_w;
    logic rd_c;
    assign wr_c = i_clk_en && i_sfr_wr && i_sfr_addr == fcr_pkg::ADDR_CTRL;
    assign on_w = wr_c && i_sfr_wdata[2:0] != 3'h0;
    assign rd_c = i_clk_en && i_sfr_rd;
    ////////////////////////////////////////
    en_excl_a: assert property (!(o_lc_osc_en && o_divider_en))
        else $error("both counted clocks enabled");
    off_now_a: assert property (wr_c && i_sfr_wdata[2:0] == 3'h0
        |=> !o_lc_osc_en && !o_divider_en) else $error("enable after off");
    lc_pick_a: assert property (on_w && !i_sfr_wdata[5]
        |=> o_lc_osc_en) else $error("lc clock not enabled");
    div_pick_a: assert property (on_w && i_sfr_wdata[5]
        |=> o_divider_en) else $error("divider clock not enabled");
    trig_clr_a: assert property (on_w && i_sfr_wdata[6]
        |=> !o_irq [*3]) else $error("done not cleared by trigger");
    done_set_a: assert property (wr_c && i_sfr_wdata[7:6] == 2'h2
        |=> o_irq) else $error("done write not taken");
    irq_hold_a: assert property (o_irq && !wr_c |=> o_irq)
        else $error("request dropped without write");
    top_zero_a: assert property (i_clk_en && i_xreg_rd &&
        i_xreg_addr == fcr_pkg::ADDR_TALLY0 |=> o_xreg_rdata == 8'h00)
        else $error("tally upper byte not zero");
    rsv_zero_a: assert property (rd_c && i_sfr_addr ==
        fcr_pkg::ADDR_CTRL |=> o_sfr_rdata[4:3] == 2'h0)
        else $error("reserved control bits set");
    cover property ($rose(o_irq));
    cover property (on_w && i_sfr_wdata[5]);
    cover property (o_irq && i_clk_en && i_xreg_rd);
endmodule
bind fcr_counter fcr_monitor fcr_monitor_inst (.i_clock, .i_rst_n,
    .i_clk_en, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata,
    .o_sfr_rdata, .i_xreg_addr, .i_xreg_rd, .o_xreg_rdata,
    .o_lc_osc_en, .o_divider_en, .o_irq);

// *** sim/fcr_clk_model.sv ***
// Purpose: clock sources around the frequency counter
// Assumes: sources phase-locked to the system clock
// Notes: periods 2,4,8,16,32 cycles so tallies are exact
`timescale 1ns/1ps
module fcr_clk_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // counted clock enables
    input wire logic i_lc_en,
    input wire logic i_div_en,
    // sources
    output logic o_gpio,
    output logic o_osc24,
    output logic o_xo,
    output logic o_sleep,
    output logic o_lc,
    output logic o_div
);
    logic [4:0] ph;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph <= 5'h00;
        end else begin
            ph <= ph + 5'h01;
        end
    end
    assign o_gpio = ph[2];
    assign o_osc24 = ph[1];
    assign o_xo = ph[3];
    assign o_sleep = ph[4];
    // oscillators idle low while switched off
    assign o_lc = i_lc_en & ph[0];
    assign o_div = i_div_en & ph[1];
endmodule

// *** sim/fcr_counter_tb.sv ***
// Purpose: self-checking bench of the frequency counter
// Assumes: sources from fcr_clk_model
// Notes: expected tallies follow from the source periods
`timescale 1ns/1ps
module clock_ratio_frequency_counter_tb;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_clk_en = 1'b1;
    logic [7:0] i_sfr_addr = 8'h00;
    logic i_sfr_wr = 1'b0;
    logic i_sfr_rd = 1'b0;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic [15:0] i_xreg_addr = 16'h0000;
    logic i_xreg_rd = 1'b0;
    logic [7:0] o_sfr_rdata, o_xreg_rdata, r;
    logic gpio, osc, xo, slp, lc, dv, lc_en, dv_en, o_irq;
    logic [31:0] t;
    int bad_count = 0;
    int check_count = 0;
    fcr_counter fcr_counter_inst (.i_clock, .i_rst_n, .i_clk_en,
        .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata,
        .i_xreg_addr, .i_xreg_rd, .o_xreg_rdata, .i_gpio_ref_clk(gpio),
        .i_osc24_clk(osc), .i_crystal_ref_clock(xo), .i_sleep_tick_clk(slp),
        .i_lc_tank_oscillator(lc), .i_divider_clk(dv), .o_lc_osc_en(lc_en),
        .o_divider_en(dv_en), .o_irq);
    fcr_clk_model fcr_clk_model_inst (.i_clock, .i_rst_n, .i_lc_en(lc_en),
        .i_div_en(dv_en), .o_gpio(gpio), .o_osc24(osc), .o_xo(xo),
        .o_sleep(slp), .o_lc(lc), .o_div(dv));
    initial begin
        forever #12.5 i_clock = ~i_clock;
    end
    ////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_clock);
        i_sfr_addr <= a;
        i_sfr_wdata <= d;
        i_sfr_wr <= 1'b1;
        @(posedge i_clock);
        i_sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clock);
        i_sfr_addr <= a;
        i_sfr_rd <= 1'b1;
        @(posedge i_clock);
        i_sfr_rd <= 1'b0;
        #1;
        r = o_sfr_rdata;
    endtask
    // bytes are read one by one, so a running tally may move between them
    task automatic xr(input logic [15:0] a);
        @(posedge i_clock);
        i_xreg_addr <= a;
        i_xreg_rd <= 1'b1;
        @(posedge i_clock);
        i_xreg_rd <= 1'b0;
        #1;
        t = {t[23:0], o_xreg_rdata};
    endtask
    task automatic tally();
        for (int k = 0; k < 4; k++) begin
            xr(fcr_pkg::ADDR_TALLY0 + 16'(k));
        end
    endtask
    task automatic wait_irq();
        int n = 0;
        while (o_irq !== 1'b1 && n < 3000) begin
            @(posedge i_clock);
            n++;
        end
        if (n == 3000) begin
            chk("irq", 32'h1, {31'h0, o_irq});
            give_verdict();
        end
    endtask
    // software keeps intervals short enough that the tally cannot wrap
    task automatic measure(input logic [7:0] e, c, input logic [31:0] x);
        wr(fcr_pkg::ADDR_EXP, e);
        wr(fcr_pkg::ADDR_CTRL, c | 8'h40);
        chk("lc_en", {31'h0, !c[5]}, {31'h0, lc_en});
        wait_irq();
        rd(fcr_pkg::ADDR_CTRL);
        chk("ctrl", {24'h0, c | 8'h80}, {24'h0, r});
        tally();
        chk("tally", x, t);
        repeat (20) @(posedge i_clock);
        tally();
        chk("held", x, t);
        wr(fcr_pkg::ADDR_CTRL, c);
        chk("irq", 32'h0, {31'h0, o_irq});
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        rd(fcr_pkg::ADDR_CTRL);
        chk("ctrl", 32'h0, {24'h0, r});
        chk("pins", 32'h0, {29'h0, lc_en, dv_en, o_irq});
        wr(fcr_pkg::ADDR_CTRL, 8'h18);
        rd(fcr_pkg::ADDR_CTRL);
        chk("rsv", 32'h0, {24'h0, r});
        wr(fcr_pkg::ADDR_EXP, 8'hFF);
        rd(fcr_pkg::ADDR_EXP);
        chk("exp", 32'h3F, {24'h0, r});
        rd(8'h9C);
        chk("unmapped", 32'h0, {24'h0, r});
        wr(fcr_pkg::ADDR_CTRL, 8'h01);
        repeat (30) @(posedge i_clock);
        rd(fcr_pkg::ADDR_CTRL);
        chk("idle", 32'h1, {24'h0, r});
        tally();
        chk("idle", 32'h0, t);
    endtask
    task automatic t_modes();
        logic [7:0] m [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
        logic [31:0] x [5] = '{32'h8, 32'h4, 32'h1, 32'h10, 32'h20};
        for (int i = 0; i < 5; i++) begin
            measure(8'h00, m[i], x[i]);
        end
        measure(8'h00, 8'h21, 32'h4);
    endtask
    task automatic t_length();
        logic [7:0] e [5] = '{8'h01, 8'h02, 8'h03, 8'h2C, 8'h3F};
        logic [31:0] x [5] = '{32'hC, 32'h10, 32'h18, 32'h4, 32'h4};
        for (int i = 0; i < 5; i++) begin
            measure(e[i], 8'h01, x[i]);
        end
    endtask
    task automatic t_restart();
        wr(fcr_pkg::ADDR_EXP, 8'h02);
        wr(fcr_pkg::ADDR_CTRL, 8'h41);
        repeat (24) @(posedge i_clock);
        tally();
        chk("live", 32'h1, {31'h0, t != 0 && t < 32'h10});
        wr(fcr_pkg::ADDR_CTRL, 8'h41);
        xr(fcr_pkg::ADDR_TALLY3);
        chk("cleared", 32'h0, {24'h0, t[7:0]});
        wait_irq();
        tally();
        chk("tally", 32'h10, t);
        wr(fcr_pkg::ADDR_CTRL, 8'h81);
        repeat (20) @(posedge i_clock);
        chk("irq", 32'h1, {31'h0, o_irq});
        wr(fcr_pkg::ADDR_CTRL, 8'h41);
        repeat (16) @(posedge i_clock);
        wr(fcr_pkg::ADDR_CTRL, 8'h00);
        chk("pins", 32'h0, {29'h0, lc_en, dv_en, o_irq});
        repeat (60) @(posedge i_clock);
        rd(fcr_pkg::ADDR_CTRL);
        chk("off", 32'h0, {24'h0, r});
        measure(8'h00, 8'h01, 32'h8);
        // reserved interval codes stay busy, no source ever ticks
        wr(fcr_pkg::ADDR_CTRL, 8'h45);
        repeat (40) @(posedge i_clock);
        rd(fcr_pkg::ADDR_CTRL);
        chk("rsv_mode", 32'h45, {24'h0, r});
        wr(fcr_pkg::ADDR_CTRL, 8'h00);
        // a write while the clock enable is low must not land
        @(posedge i_clock);
        i_clk_en <= 1'b0;
        wr(fcr_pkg::ADDR_CTRL, 8'h80);
        @(posedge i_clock);
        i_clk_en <= 1'b1;
        chk("frozen", 32'h0, {31'h0, o_irq});
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_regs();
        t_modes();
        t_length();
        t_restart();
        give_verdict();
    end
endmodule
